// >>> hdl/pced_regs.vh
// Register offsets, field positions, reset values for the pin change edge detector.
// Assumes an APB slave with 32-bit data; offsets are word indices, byte address = 4 * index.
// How it works
// - Enabled falling edge sets the pin change flag and interrupt flag.
// - Enabled rising edge sets the pin change flag and interrupt flag.
// - A zero enable bit ignores that edge direction entirely on that pin.
// - Ports A, B, C each have an eight-bit read-write falling enable, reset zero.
// - Ports A, B, C each have an eight-bit read-write rising enable, reset zero.
// - Port E implements only bit 3 enables, for port E pin 3.
// - Reset-pin or low-voltage-program config disables port E pin 3 detection.
// - Change flags set by hardware, cleared by software writing zero, reset zero.
`ifndef PCED_REGS_VH
`define PCED_REGS_VH
`define PCED_IDX_WIDTH 12
`define PCED_IDX_PA_FLAG 12'hF0A
`define PCED_IDX_PA_FALL 12'hF0B
`define PCED_IDX_PA_RISE 12'hF0C
`define PCED_IDX_PB_FLAG 12'hF12
`define PCED_IDX_PB_FALL 12'hF13
`define PCED_IDX_PB_RISE 12'hF14
`define PCED_IDX_PC_FLAG 12'hF1A
`define PCED_IDX_PC_FALL 12'hF1B
`define PCED_IDX_PC_RISE 12'hF1C
`define PCED_IDX_PE_FLAG 12'hF27
`define PCED_IDX_PE_FALL 12'hF28
`define PCED_IDX_PE_RISE 12'hF29
`define PCED_IDX_IRQ_STAT 12'hF30
`define PCED_IDX_IRQ_MASK 12'hF31
`define PCED_PE_BIT 3
`define PCED_PE_MASK 8'h08
`define PCED_RESET_8 8'h00
`define PCED_IRQ_CHANGE_BIT 0
`define PCED_SETTLE_CYCLES 3'h4
`endif

// >>> hdl/pced_sync.v
// Three-stage synchroniser with agreement filter for a bus of pin inputs.
// Assumes pins are asynchronous to clk.
`timescale 1ns/100ps
module pced_sync #(
    parameter WIDTH = 25
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] pin_async,
    output reg [WIDTH-1:0] pin_level
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;

    always @(posedge clk) begin
        if (reset) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            pin_level <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pin_async;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    pin_level[i] <= stage3[i];
                end
            end
        end
    end
endmodule // pced_sync

// >>> hdl/pced_top.v
// Pin change edge detector for ports A, B, C and port E bit 3, with APB registers.
// Assumes APB master on clk; pins are asynchronous and are synchronised here.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "pced_regs.vh"
module pced_top (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] porta_pin,
    input wire [7:0] portb_pin,
    input wire [7:0] portc_pin,
    input wire port_e_bit3_pin,
    input wire external_reset_pin_enable,
    input wire low_voltage_program_enable,
    output reg pin_change_interrupt,
    output reg irq
);
    reg [7:0] porta_fall_enable;
    reg [7:0] porta_rise_enable;
    reg [7:0] portb_fall_enable;
    reg [7:0] portb_rise_enable;
    reg [7:0] portc_fall_enable;
    reg [7:0] portc_rise_enable;
    reg porte_fall_bit;
    reg porte_rise_bit;
    reg [7:0] porta_change_flags;
    reg [7:0] portb_change_flags;
    reg [7:0] portc_change_flags;
    reg porte_flag_bit;
    reg irq_status;
    reg irq_mask;
    reg [24:0] prev_level;
    reg prev_valid;
    reg [2:0] settle_count;
    reg ext_sync1;
    reg ext_sync2;
    reg ext_sync3;
    reg ext_level;
    reg lvp_sync1;
    reg lvp_sync2;
    reg lvp_sync3;
    reg lvp_level;
    wire cfg_block;
    wire [24:0] pin_level;
    wire [24:0] fall_en;
    wire [24:0] rise_en;
    wire [24:0] fall_hit;
    wire [24:0] rise_hit;
    wire [24:0] edge_hit;
    wire wr_access;
    wire rd_access;
    wire [`PCED_IDX_WIDTH-1:0] idx;
    wire addr_ok;
    wire [7:0] wbyte;
    wire any_flag;
    reg [7:0] next_rdata;
    reg next_err;
    wire setup_phase;
    wire wr_pa_flag;
    wire wr_pa_fall;
    wire wr_pa_rise;
    wire wr_pb_flag;
    wire wr_pb_fall;
    wire wr_pb_rise;
    wire wr_pc_flag;
    wire wr_pc_fall;
    wire wr_pc_rise;
    wire wr_pe_flag;
    wire wr_pe_fall;
    wire wr_pe_rise;
    wire wr_irq_stat;
    wire wr_irq_mask;

    pced_sync #(
        .WIDTH(25)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .pin_async({port_e_bit3_pin, portc_pin, portb_pin, porta_pin}),
        .pin_level(pin_level)
    );

    // each strap synchronised and filtered on its own
    always @(posedge clk) begin
        if (reset) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_sync3 <= 1'b0;
            ext_level <= 1'b0;
            lvp_sync1 <= 1'b0;
            lvp_sync2 <= 1'b0;
            lvp_sync3 <= 1'b0;
            lvp_level <= 1'b0;
        end else begin
            ext_sync1 <= external_reset_pin_enable;
            ext_sync2 <= ext_sync1;
            ext_sync3 <= ext_sync2;
            lvp_sync1 <= low_voltage_program_enable;
            lvp_sync2 <= lvp_sync1;
            lvp_sync3 <= lvp_sync2;
            if (ext_sync2 == ext_sync3) begin
                ext_level <= ext_sync3;
            end
            if (lvp_sync2 == lvp_sync3) begin
                lvp_level <= lvp_sync3;
            end
        end
    end

    // either strap takes port E pin 3 away
    assign cfg_block = ext_level | lvp_level;

    assign fall_en = {porte_fall_bit & ~cfg_block,
        portc_fall_enable,
        portb_fall_enable,
        porta_fall_enable};
    assign rise_en = {porte_rise_bit & ~cfg_block,
        portc_rise_enable,
        portb_rise_enable,
        porta_rise_enable};

    assign fall_hit = prev_level & ~pin_level & fall_en;

    assign rise_hit = ~prev_level & pin_level & rise_en;

    assign edge_hit = prev_valid ? (fall_hit | rise_hit) : 25'h0000000;

    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & penable & ~pwrite;
    assign idx = paddr[`PCED_IDX_WIDTH+1:2];
    assign addr_ok = (paddr[31:`PCED_IDX_WIDTH+2] == 18'h00000) & (paddr[1:0] == 2'h0);
    assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
    // Setup cycle of a transfer
    assign setup_phase = psel & ~penable;

    // Write of zero clears a flag bit; set wins
    function [7:0] flag_next;
        input [7:0] cur;
        input [7:0] hit;
        input clr_sel;
        input [7:0] data;
        begin
            if (clr_sel) begin
                flag_next = (cur & data) | hit;
            end else begin
                flag_next = cur | hit;
            end
        end
    endfunction

    function sel_wr;
        input [`PCED_IDX_WIDTH-1:0] a;
        input [`PCED_IDX_WIDTH-1:0] b;
        input ok;
        input wr;
        input lane;
        begin
            sel_wr = wr & ok & lane & (a == b);
        end
    endfunction

    // Write strobes, byte lane 0 only: flag registers
    assign wr_pa_flag = sel_wr(idx, `PCED_IDX_PA_FLAG, addr_ok, wr_access, pstrb[0]);
    assign wr_pb_flag = sel_wr(idx, `PCED_IDX_PB_FLAG, addr_ok, wr_access, pstrb[0]);
    assign wr_pc_flag = sel_wr(idx, `PCED_IDX_PC_FLAG, addr_ok, wr_access, pstrb[0]);
    assign wr_pe_flag = sel_wr(idx, `PCED_IDX_PE_FLAG, addr_ok, wr_access, pstrb[0]);

    // Enable and interrupt control registers
    assign wr_pa_fall = sel_wr(idx, `PCED_IDX_PA_FALL, addr_ok, wr_access, pstrb[0]);
    assign wr_pa_rise = sel_wr(idx, `PCED_IDX_PA_RISE, addr_ok, wr_access, pstrb[0]);
    assign wr_pb_fall = sel_wr(idx, `PCED_IDX_PB_FALL, addr_ok, wr_access, pstrb[0]);
    assign wr_pb_rise = sel_wr(idx, `PCED_IDX_PB_RISE, addr_ok, wr_access, pstrb[0]);
    assign wr_pc_fall = sel_wr(idx, `PCED_IDX_PC_FALL, addr_ok, wr_access, pstrb[0]);
    assign wr_pc_rise = sel_wr(idx, `PCED_IDX_PC_RISE, addr_ok, wr_access, pstrb[0]);
    assign wr_pe_fall = sel_wr(idx, `PCED_IDX_PE_FALL, addr_ok, wr_access, pstrb[0]);
    assign wr_pe_rise = sel_wr(idx, `PCED_IDX_PE_RISE, addr_ok, wr_access, pstrb[0]);
    assign wr_irq_stat = sel_wr(idx, `PCED_IDX_IRQ_STAT, addr_ok, wr_access, pstrb[0]);
    assign wr_irq_mask = sel_wr(idx, `PCED_IDX_IRQ_MASK, addr_ok, wr_access, pstrb[0]);

    // Port E bit 3 back into its byte lane
    function [7:0] porte_byte;
        input bit_val;
        begin
            porte_byte = bit_val ? `PCED_PE_MASK : `PCED_RESET_8;
        end
    endfunction

    always @(posedge clk) begin
        if (reset) begin
            porta_fall_enable <= `PCED_RESET_8;
            porta_rise_enable <= `PCED_RESET_8;
            portb_fall_enable <= `PCED_RESET_8;
            portb_rise_enable <= `PCED_RESET_8;
            portc_fall_enable <= `PCED_RESET_8;
            portc_rise_enable <= `PCED_RESET_8;
            porte_fall_bit <= 1'b0;
            porte_rise_bit <= 1'b0;
            irq_mask <= 1'b0;
        end else begin
            if (wr_pa_fall) begin
                porta_fall_enable <= wbyte;
            end
            if (wr_pa_rise) begin
                porta_rise_enable <= wbyte;
            end
            if (wr_pb_fall) begin
                portb_fall_enable <= wbyte;
            end
            if (wr_pb_rise) begin
                portb_rise_enable <= wbyte;
            end
            if (wr_pc_fall) begin
                portc_fall_enable <= wbyte;
            end
            if (wr_pc_rise) begin
                portc_rise_enable <= wbyte;
            end
            if (wr_pe_fall) begin
                porte_fall_bit <= wbyte[`PCED_PE_BIT];
            end
            if (wr_pe_rise) begin
                porte_rise_bit <= wbyte[`PCED_PE_BIT];
            end
            if (wr_irq_mask) begin
                irq_mask <= wbyte[`PCED_IRQ_CHANGE_BIT];
            end
        end
    end

    // sticky flags, software clear by zero, set wins
    always @(posedge clk) begin
        if (reset) begin
            porta_change_flags <= `PCED_RESET_8;
            portb_change_flags <= `PCED_RESET_8;
            portc_change_flags <= `PCED_RESET_8;
            porte_flag_bit <= 1'b0;
            prev_level <= 25'h0000000;
        end else begin
            prev_level <= pin_level;
            porta_change_flags <= flag_next(porta_change_flags, edge_hit[7:0], wr_pa_flag, wbyte);
            portb_change_flags <= flag_next(portb_change_flags, edge_hit[15:8], wr_pb_flag, wbyte);
            portc_change_flags <= flag_next(portc_change_flags, edge_hit[23:16], wr_pc_flag, wbyte);
            if (edge_hit[24]) begin
                porte_flag_bit <= 1'b1;
            end else if (wr_pe_flag) begin
                porte_flag_bit <= porte_flag_bit & wbyte[`PCED_PE_BIT];
            end
        end
    end

    // no edge until synchroniser holds real pin levels
    always @(posedge clk) begin
        if (reset) begin
            settle_count <= 3'h0;
            prev_valid <= 1'b0;
        end else begin
            if (settle_count != `PCED_SETTLE_CYCLES) begin
                settle_count <= settle_count + 3'h1;
            end
            prev_valid <= (settle_count == `PCED_SETTLE_CYCLES);
        end
    end

    // interrupt flag is OR of flags
    assign any_flag = (|porta_change_flags) | (|portb_change_flags) | (|portc_change_flags) | porte_flag_bit;

    // Sticky status on any enabled edge, write one clears
    always @(posedge clk) begin
        if (reset) begin
            irq_status <= 1'b0;
            pin_change_interrupt <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (|edge_hit) begin
                irq_status <= 1'b1;
            end else if (wr_irq_stat & wbyte[`PCED_IRQ_CHANGE_BIT]) begin
                irq_status <= 1'b0;
            end
            pin_change_interrupt <= any_flag;
            irq <= irq_status & irq_mask;
        end
    end

    // Read mux and unmapped decode
    always @* begin
        next_rdata = 8'h00;
        next_err = 1'b0;
        if (!addr_ok) begin
            next_err = 1'b1;
        end else begin
            case (idx)
                `PCED_IDX_PA_FLAG: next_rdata = porta_change_flags;
                `PCED_IDX_PA_FALL: next_rdata = porta_fall_enable;
                `PCED_IDX_PA_RISE: next_rdata = porta_rise_enable;
                `PCED_IDX_PB_FLAG: next_rdata = portb_change_flags;
                `PCED_IDX_PB_FALL: next_rdata = portb_fall_enable;
                `PCED_IDX_PB_RISE: next_rdata = portb_rise_enable;
                `PCED_IDX_PC_FLAG: next_rdata = portc_change_flags;
                `PCED_IDX_PC_FALL: next_rdata = portc_fall_enable;
                `PCED_IDX_PC_RISE: next_rdata = portc_rise_enable;
                `PCED_IDX_PE_FLAG: next_rdata = porte_byte(porte_flag_bit);
                `PCED_IDX_PE_FALL: next_rdata = porte_byte(porte_fall_bit);
                `PCED_IDX_PE_RISE: next_rdata = porte_byte(porte_rise_bit);
                `PCED_IDX_IRQ_STAT: next_rdata = {7'h00, irq_status};
                `PCED_IDX_IRQ_MASK: next_rdata = {7'h00, irq_mask};
                default: next_err = 1'b1;
            endcase
        end
    end

    // Zero-wait APB answer, registered
    always @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & next_err;
            if (setup_phase & ~pwrite) begin
                prdata <= {24'h000000, next_rdata};
            end
        end
    end

    wire unused_rd;
    assign unused_rd = rd_access;
endmodule // pced_top

// >>> sim/pced_props.sv
// Checker for pced_top: APB answer timing and flag clearing.
// Assumes binding to pced_top; sees its ports only.
`timescale 1ns/100ps
module pced_props (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire pin_change_interrupt,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no pready after setup");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err_pair;
        pslverr |-> pready;
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
    property p_misalign;
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
    property p_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("read data above bit 7");
    property p_refuse;
        pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused read not zero");
    property p_rst;
        disable iff (1'b0) reset |=> !pready && !pin_change_interrupt && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_clear;
        $fell(pin_change_interrupt) |-> $past(psel && penable && pwrite, 2) || $past(reset, 2) || $past(reset);
    endproperty
    a_clear: assert property (p_clear) else $error("interrupt fell without write");
    c_err: cover property (pslverr);
    c_int: cover property ($rose(pin_change_interrupt));
    c_irq: cover property ($rose(irq));
endmodule // pced_props
bind pced_top pced_props pced_props_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_change_interrupt(pin_change_interrupt), .irq(irq));

// >>> sim/pced_pins.sv
// Pin-side model: drives port pins to the levels the bench asks for.
// Assumes each level is held for several clk cycles.
`timescale 1ns/100ps
module pced_pins (
    input wire clk,
    input wire [24:0] want,
    output reg [7:0] porta_pin,
    output reg [7:0] portb_pin,
    output reg [7:0] portc_pin,
    output reg port_e_bit3_pin
);
    always @(posedge clk) begin
        {port_e_bit3_pin, portc_pin, portb_pin, porta_pin} <= want;
    end
endmodule // pced_pins

// >>> sim/tb.sv
// Bench for pced_top: APB register access and pin edge scenarios.
// Assumes pced_pins drives the pins; one idle cycle between transfers.
`timescale 1ns/100ps
module tb;
    reg clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    reg [31:0] paddr = 0, pwdata = 0;
    reg [24:0] want = 25'h0808080;
    reg ext_en = 0, lvp_en = 0;
    reg [1:0] skew = 0;
    wire [31:0] prdata;
    wire pready, pslverr, pci, irq, pe;
    wire [7:0] pa, pb, pc;
    integer miscompares = 0, checks = 0, cyc = 0;
    always #20 clk = ~clk;
    pced_pins pced_pins_inst (.clk(clk), .want(want), .porta_pin(pa), .portb_pin(pb), .portc_pin(pc),
        .port_e_bit3_pin(pe));
    pced_top pced_top_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porta_pin(pa), .portb_pin(pb), .portc_pin(pc), .port_e_bit3_pin(pe),
        .external_reset_pin_enable(ext_en), .low_voltage_program_enable(lvp_en),
        .pin_change_interrupt(pci), .irq(irq));
    task end_of_test;
        begin
            if (miscompares == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [8*10-1:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task xfer(input w, input [11:0] idx, input [7:0] d, input [7:0] exp, input err);
        integer n;
        begin
            psel <= 1;
            pwrite <= w;
            paddr <= {18'h0, idx, skew};
            pwdata <= {24'h0, d};
            @(posedge clk);
            penable <= 1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1) begin
                n = n + 1;
                @(posedge clk);
            end
            chk("wait_cnt", n, 0);
            chk("pslverr", pslverr, err);
            if (!w) chk("prdata", prdata, {24'h0, exp});
            psel <= 0;
            penable <= 0;
            @(posedge clk);
        end
    endtask
    task t_regs;
        integer i;
        reg [11:0] a;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                a = 12'hF0B + 8 * (i / 2) + i % 2;
                xfer(0, a, 0, 8'h00, 0);
                xfer(1, a, 8'hA5 ^ i, 0, 0);
                xfer(0, a, 0, 8'hA5 ^ i, 0);
                xfer(1, a, 8'h00, 0, 0);
            end
            xfer(1, 12'hF28, 8'hFF, 0, 0);
            xfer(0, 12'hF28, 0, 8'h08, 0);
            xfer(1, 12'hF29, 8'hFF, 0, 0);
            xfer(0, 12'hF29, 0, 8'h08, 0);
            xfer(0, 12'hF0D, 0, 8'h00, 1);
            skew = 1;
            xfer(0, 12'hF0B, 0, 8'h00, 1);
            skew = 0;
        end
    endtask
    task t_edges;
        integer p;
        reg [11:0] a;
        begin
            for (p = 0; p < 3; p = p + 1) begin
                a = 12'hF0A + 8 * p;
                xfer(1, a + 1, 8'h80, 0, 0);
                xfer(1, a + 2, 8'h01, 0, 0);
                want <= want | (25'h3 << 8 * p);
                wt(8);
                xfer(0, a, 0, 8'h01, 0);
                want <= want & ~(25'h82 << 8 * p);
                wt(8);
                xfer(0, a, 0, 8'h81, 0);
                chk("interrupt", pci, 1);
                xfer(1, a, 8'h01, 0, 0);
                xfer(0, a, 0, 8'h01, 0);
                xfer(1, a, 8'h00, 0, 0);
                xfer(1, a + 1, 8'h00, 0, 0);
                xfer(1, a + 2, 8'h00, 0, 0);
                want <= want ^ (25'h81 << 8 * p);
                wt(8);
                xfer(0, a, 0, 8'h00, 0);
                chk("interrupt", pci, 0);
            end
        end
    endtask
    task t_porte;
        begin
            ext_en <= 1;
            want[24] <= 1;
            wt(8);
            xfer(0, 12'hF27, 0, 8'h00, 0);
            ext_en <= 0;
            lvp_en <= 1;
            want[24] <= 0;
            wt(8);
            xfer(0, 12'hF27, 0, 8'h00, 0);
            lvp_en <= 0;
            wt(8);
            want[24] <= 1;
            wt(8);
            xfer(0, 12'hF27, 0, 8'h08, 0);
            xfer(1, 12'hF27, 8'h00, 0, 0);
            xfer(0, 12'hF27, 0, 8'h00, 0);
        end
    endtask
    task t_irq;
        begin
            xfer(0, 12'hF30, 0, 8'h01, 0);
            chk("irq", irq, 0);
            xfer(1, 12'hF31, 8'h01, 0, 0);
            wt(1);
            chk("irq", irq, 1);
            xfer(1, 12'hF30, 8'h01, 0, 0);
            wt(1);
            chk("irq", irq, 0);
            xfer(0, 12'hF30, 0, 8'h00, 0);
        end
    endtask
    task t_reset;
        begin
            reset <= 1;
            wt(2);
            reset <= 0;
            xfer(1, 12'hF0C, 8'h80, 0, 0);
            wt(8);
            xfer(0, 12'hF0A, 0, 8'h00, 0);
            chk("interrupt", pci, 0);
            xfer(0, 12'hF28, 0, 8'h00, 0);
            xfer(1, 12'hF0C, 8'h00, 0, 0);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    initial begin
        wt(2);
        reset <= 0;
        wt(4);
        t_regs;
        t_edges;
        t_porte;
        t_irq;
        t_reset;
        end_of_test;
    end
endmodule // tb
